// file: shared/sys_config_defines.vh
// Offsets, field positions, reset values for the system configuration bank.
// Assumes a 32-bit classic Wishbone slave on a single 10 MHz clock.
`ifndef SYS_CONFIG_DEFINES_VH
`define SYS_CONFIG_DEFINES_VH

// ==========================================
// Register byte offsets
`define OFS_REMAP 12'h008
`define OFS_VERSION 12'h024
`define OFS_ETH_CLK 12'h030
`define OFS_REG_TRIM 12'h150
`define OFS_CAL_CTRL 12'h160
`define OFS_MAN_TRIM 12'h168
`define OFS_CAL_STAT 12'h16C

// ==========================================
// Writable bit masks and reset values
`define MASK_REMAP 32'h00000001
`define RST_REMAP 32'h00000001
`define MASK_ETH_CLK 32'hFFFFBFFF
`define RST_ETH_CLK 32'h00058000
`define MASK_REG_TRIM 32'hFF33FF1F
`define RST_REG_TRIM 32'h00000E0F
`define MASK_CAL_CTRL 32'h013F0107
`define RST_CAL_CTRL 32'h00330003
`define MASK_MAN_TRIM 32'h0000003F
`define RST_MAN_TRIM 32'h00000033

// ==========================================
// Field positions
`define BIT_EXT_PATH 27
`define BIT_RMII_EN 13
`define BIT_IF_TYPE 2
`define BIT_TRIM_SRC 8
`define BIT_REMAP_BOOT 0
`define BIT_REF_SEL 18
`define BIT_RX_INV 4
`define BIT_TX_INV 3
`define BIT_CAL_MODE 2
`define BIT_CAL_ANALOG 1
`define BIT_CAL_AUTO 0

`endif

// file: logic/system_config_regs.v
// System configuration register bank behind a classic Wishbone slave.
// Holds memory remap, boot pin status, Ethernet clock setup and trims.
// Assumes boot pins are asynchronous; analog consumers sit on the outputs.
// Assumes the calibrator inputs are driven from this same clock.
// Assumes the master drops its request for a cycle after each ack.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "sys_config_defines.vh"

module system_config_regs (
  input wire clock,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [1:0] boot_select_pin,
  input wire upgrade_pin,
  input wire [5:0] calibrator_trim,
  input wire calibrator_compare,
  output wire remap_to_boot,
  output wire external_mgmt_path_select,
  output wire [1:0] operation_mode,
  output wire [4:0] phy_station_number,
  output wire ref_clock_24mhz,
  output wire rmii_enable,
  output wire mii_enable,
  output wire rgmii_enable,
  output wire [2:0] tx_clock_delay_tap,
  output wire [4:0] rx_clock_delay_tap,
  output wire rx_clock_invert,
  output wire tx_clock_invert,
  output wire [1:0] tx_clock_source,
  output wire [5:0] regulator_b_code,
  output wire [4:0] regulator_a_code,
  output wire calibration_mode_select,
  output wire calibration_analog_enable,
  output wire auto_calibration_enable,
  output wire [5:0] resistor_trim
);

  // ==========================================
  // Storage
  // Full 32-bit images; bits outside each writable mask keep reset value
  reg [31:0] remap;
  reg [31:0] eth_clk;
  reg [31:0] reg_trim;
  reg [31:0] cal_ctrl;
  reg [31:0] man_trim;
  // Bus answer, high for one cycle per accepted request
  reg ack;
  // Read word chosen in the request cycle
  reg [31:0] next_read_data;
  // Filtered pins: boot select in 2:1, upgrade in 0
  reg [2:0] boot_state;
  // Registered resistor trim as driven to the resistor
  reg [5:0] trim_out;
  // Raw pins, then second and third synchroniser stages
  wire [2:0] pin_raw;
  wire [2:0] pin_second;
  wire [2:0] pin_third;
  // Read-only register images
  wire [31:0] version_image;
  wire [31:0] status_image;
  // Bus qualifiers
  wire [31:0] wmask;
  wire req;
  wire wr;
  // Per-register address hits
  wire hit_remap;
  wire hit_version;
  wire hit_eth_clk;
  wire hit_reg_trim;
  wire hit_cal_ctrl;
  wire hit_man_trim;
  wire hit_cal_stat;
  // Per-register write strobes, live only at the ack edge
  wire wr_remap;
  wire wr_eth_clk;
  wire wr_reg_trim;
  wire wr_cal_ctrl;
  wire wr_man_trim;
  // Loop index of the pin synchroniser
  genvar pin_index;

  // ==========================================
  // Bus decode
  // Exact match of the byte address against one offset
  function address_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      address_hit = (addr == offset);
    end
  endfunction

  // Byte lane mask from select
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // A request is live while cycle and strobe are both high
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign wr = req & wb_we_i & ack;
  assign wb_ack_o = ack;

  // Offset decode, shared by write strobes and read mux
  assign hit_remap = address_hit(wb_adr_i, `OFS_REMAP);
  assign hit_version = address_hit(wb_adr_i, `OFS_VERSION);
  assign hit_eth_clk = address_hit(wb_adr_i, `OFS_ETH_CLK);
  assign hit_reg_trim = address_hit(wb_adr_i, `OFS_REG_TRIM);
  assign hit_cal_ctrl = address_hit(wb_adr_i, `OFS_CAL_CTRL);
  assign hit_man_trim = address_hit(wb_adr_i, `OFS_MAN_TRIM);
  assign hit_cal_stat = address_hit(wb_adr_i, `OFS_CAL_STAT);

  // only mapped writable registers take writes
  assign wr_remap = wr & hit_remap;
  assign wr_eth_clk = wr & hit_eth_clk;
  assign wr_reg_trim = wr & hit_reg_trim;
  assign wr_cal_ctrl = wr & hit_cal_ctrl;
  assign wr_man_trim = wr & hit_man_trim;

  // Masked byte-lane merge
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] lanes;
    input [31:0] writable;
    begin
      merge = (old & ~(lanes & writable)) | (data & lanes & writable);
    end
  endfunction

  // ==========================================
  // Bus answer
  // Ack one cycle after request, low the next cycle; a held
  // request is therefore answered once every two cycles
  // Every request is answered, mapped or not, so the bus never hangs
  always @(posedge clock) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ==========================================
  // Pin synchroniser
  // Raw pin vector, same order as the filtered image
  assign pin_raw = {boot_select_pin, upgrade_pin};

  // Three flops per pin; only stage two reads stage one
  // Pins are asynchronous; reset clears the chain to zero
  generate
    for (pin_index = 0; pin_index < 3; pin_index = pin_index + 1) begin : g_pin_sync
      reg [2:0] chain;
      // Shift the pin in; stage one may be metastable
      always @(posedge clock) begin
        if (!rst_n) begin
          chain <= 3'h0;
        end else begin
          chain <= {chain[1:0], pin_raw[pin_index]};
        end
      end
      // Stages two and three go to the agreement test
      assign pin_second[pin_index] = chain[1];
      assign pin_third[pin_index] = chain[2];
    end
  endgenerate

  // boot select and upgrade pins filtered
  // A change counts once stages two and three agree
  always @(posedge clock) begin
    if (!rst_n) begin
      boot_state <= 3'h0;
    end else if (pin_second == pin_third) begin
      boot_state <= pin_third;
    end
  end

  // ==========================================
  // Register writes
  // remap resets to boot path
  // Writing zero hands the local memory to the DSP
  // Only bit 0 is stored; the rest reads zero
  always @(posedge clock) begin
    if (!rst_n) begin
      remap <= `RST_REMAP;
    end else if (wr_remap) begin
      remap <= merge(remap, wb_dat_i, wmask, `MASK_REMAP);
    end
  end

  // reference select resets one
  // Whole clock image, all but one unused bit writable
  // Byte lanes let software change one field group alone
  always @(posedge clock) begin
    if (!rst_n) begin
      eth_clk <= `RST_ETH_CLK;
    end else if (wr_eth_clk) begin
      eth_clk <= merge(eth_clk, wb_dat_i, wmask, `MASK_ETH_CLK);
    end
  end

  // regulator A trim reset
  // Spare and reserved bits are stored but drive nothing
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_trim <= `RST_REG_TRIM;
    end else if (wr_reg_trim) begin
      reg_trim <= merge(reg_trim, wb_dat_i, wmask, `MASK_REG_TRIM);
    end
  end

  // auto calibration resets one
  // Reserved fields keep their stored value for software
  always @(posedge clock) begin
    if (!rst_n) begin
      cal_ctrl <= `RST_CAL_CTRL;
    end else if (wr_cal_ctrl) begin
      cal_ctrl <= merge(cal_ctrl, wb_dat_i, wmask, `MASK_CAL_CTRL);
    end
  end

  // manual trim resets 0x33
  // Six stored bits; used only when the manual source is chosen
  always @(posedge clock) begin
    if (!rst_n) begin
      man_trim <= `RST_MAN_TRIM;
    end else if (wr_man_trim) begin
      man_trim <= merge(man_trim, wb_dat_i, wmask, `MASK_MAN_TRIM);
    end
  end

  // ==========================================
  // Read path
  // Images are rebuilt every cycle from live state
  // boot select in 12:11
  assign version_image = {19'h00000, boot_state[2:1], 2'h0, boot_state[0], 8'h00};
  // Calibrator result in 5:0, compare output in bit 8
  assign status_image = {23'h000000, calibrator_compare, 2'h0, calibrator_trim};

  // read mux, unmapped offsets read zero
  // Hits are exclusive, so the order of the chain does not matter
  always @* begin
    next_read_data = 32'h00000000;
    if (hit_remap) begin
      next_read_data = remap;
    end else if (hit_version) begin
      next_read_data = version_image;
    end else if (hit_eth_clk) begin
      next_read_data = eth_clk;
    end else if (hit_reg_trim) begin
      next_read_data = reg_trim;
    end else if (hit_cal_ctrl) begin
      next_read_data = cal_ctrl;
    end else if (hit_man_trim) begin
      next_read_data = man_trim;
    end else if (hit_cal_stat) begin
      next_read_data = status_image;
    end
  end

  // Read data taken in the request cycle, shown with the ack
  always @(posedge clock) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req & ~ack) begin
      wb_dat_o <= next_read_data;
    end
  end

  // ==========================================
  // Memory routing
  // memory routing
  // One means boot path owns the local memory, zero the DSP
  // Flipping it while either side is mid-access is software's hazard
  assign remap_to_boot = remap[`BIT_REMAP_BOOT];

  // ==========================================
  // Ethernet interface controls
  // Fields are plain register bits, except the two full-interface enables decoded below
  // path select
  // Zero keeps management and media paths internal
  assign external_mgmt_path_select = eth_clk[`BIT_EXT_PATH];

  // mode code
  // Code 11 is reserved; it is passed on unchanged
  assign operation_mode = eth_clk[26:25];

  // station number
  // Five-bit address the internal PHY answers to
  assign phy_station_number = eth_clk[24:20];

  // reference choice
  // One selects the 24 MHz reference, zero the 25 MHz one
  assign ref_clock_24mhz = eth_clk[`BIT_REF_SEL];

  // reduced-MII override
  // Reduced mode wins over the type bit below
  // Software may leave the type bit set; it is simply ignored
  assign rmii_enable = eth_clk[`BIT_RMII_EN];

  // interface type
  // Both full interfaces stay off while reduced mode is on
  assign mii_enable = ~eth_clk[`BIT_RMII_EN] & ~eth_clk[`BIT_IF_TYPE];
  assign rgmii_enable = ~eth_clk[`BIT_RMII_EN] & eth_clk[`BIT_IF_TYPE];

  // delay taps
  // Raw tap counts; the delay lines decode them
  // Transmit chain has three bits
  assign tx_clock_delay_tap = eth_clk[12:10];
  // Receive chain has five bits
  assign rx_clock_delay_tap = eth_clk[9:5];

  // receive invert
  // Changing it while frames flow may glitch the receive clock
  assign rx_clock_invert = eth_clk[`BIT_RX_INV];

  // transmit invert
  // Same glitch hazard as the receive side
  assign tx_clock_invert = eth_clk[`BIT_TX_INV];

  // transmit source
  // Code 11 is reserved; it is passed on unchanged
  assign tx_clock_source = eth_clk[1:0];

  // ==========================================
  // Regulator trims
  // Trim codes reach the analog side with no synchroniser
  // low six bits
  // Upper two bits of the field are stored but drive nothing
  assign regulator_b_code = reg_trim[13:8];

  // low five bits
  // Only five of the stored bits reach the regulator
  assign regulator_a_code = reg_trim[4:0];

  // ==========================================
  // Resistor calibration
  // Calibrator inputs share this clock, so no synchroniser
  // calibration mode
  // One is reserved; software should leave it clear
  assign calibration_mode_select = cal_ctrl[`BIT_CAL_MODE];

  // analog enable
  // Clearing it powers the calibration circuit down
  assign calibration_analog_enable = cal_ctrl[`BIT_CAL_ANALOG];

  // auto calibration
  // Runs the calibrator while set
  assign auto_calibration_enable = cal_ctrl[`BIT_CAL_AUTO];

  // trim source mux
  // Zero follows the calibrator, one the manual register
  // Registered so a source flip reaches the resistor glitch-free
  always @(posedge clock) begin
    if (!rst_n) begin
      trim_out <= 6'h00;
    end else if (cal_ctrl[`BIT_TRIM_SRC]) begin
      trim_out <= man_trim[5:0];
    end else begin
      trim_out <= calibrator_trim;
    end
  end
  assign resistor_trim = trim_out;

endmodule // system_config_regs

// file: verification/system_config_regs_sva.sv
// Checker for the configuration bank ports.
// Assumes the bind below attaches it to the system_config_regs module.
`timescale 1ns/1ps
module system_config_regs_sva (
  input logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
  input logic remap_to_boot, ref_clock_24mhz, rmii_enable, mii_enable, rgmii_enable,
  input logic [4:0] phy_station_number, rx_clock_delay_tap, regulator_a_code,
  input logic [2:0] tx_clock_delay_tap,
  input logic [5:0] regulator_b_code,
  input logic calibration_mode_select, calibration_analog_enable, auto_calibration_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Bus answer
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  // ==========================================
  // Reset values and selects
  a_remap_boot_reset: assert property ($rose(rst_n) |-> remap_to_boot)
    else $error("remap reset");
  a_phy_number_reset: assert property ($rose(rst_n) |-> ref_clock_24mhz && !phy_station_number)
    else $error("phy reset");
  a_delay_tap_reset: assert property ($rose(rst_n) |-> !tx_clock_delay_tap && !rx_clock_delay_tap)
    else $error("tap reset");
  a_trim_code_reset: assert property ($rose(rst_n) |-> regulator_b_code == 6'h0E
    && regulator_a_code == 5'h0F) else $error("trim reset");
  a_cal_bits_reset: assert property ($rose(rst_n) |-> calibration_analog_enable
    && auto_calibration_enable && !calibration_mode_select) else $error("cal reset");
  a_rmii_over_type: assert property (rmii_enable |-> !mii_enable && !rgmii_enable)
    else $error("rmii override");
  a_type_one_hot: assert property (!rmii_enable |-> mii_enable ^ rgmii_enable)
    else $error("type select");
  cover property (rmii_enable);
  cover property (rgmii_enable);
  cover property (!remap_to_boot);
endmodule // system_config_regs_sva
bind system_config_regs system_config_regs_sva u_system_config_regs_sva (.*);

// file: verification/system_config_regs_tb_top.sv
// Directed bench for the configuration bank.
// Assumes one ack per request, one cycle after it.
`timescale 1ns/1ps
module system_config_regs_tb_top;
  logic clock = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, upgrade_pin = 1;
  logic calibrator_compare = 0;
  logic [11:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0;
  logic [1:0] boot_select_pin = 2'h2;
  logic [5:0] calibrator_trim = 6'h2A;
  wire [31:0] wb_dat_o;
  wire [5:0] regulator_b_code, resistor_trim;
  wire [4:0] phy_station_number, rx_clock_delay_tap, regulator_a_code;
  wire [2:0] tx_clock_delay_tap;
  wire [1:0] operation_mode, tx_clock_source;
  wire wb_ack_o, remap_to_boot, external_mgmt_path_select, ref_clock_24mhz, rmii_enable;
  wire mii_enable, rgmii_enable, rx_clock_invert, tx_clock_invert, calibration_mode_select;
  wire calibration_analog_enable, auto_calibration_enable;
  int errors = 0;
  int checks = 0;
  system_config_regs u_system_config_regs (.*);
  initial forever #50 clock = ~clock;
  task end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle, bounded wait for ack
  task bus(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    repeat (2) @(posedge clock);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 0, 4'hF, q);
    chk(q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, 4'hF, q);
  endtask
  task t_reset;
    rd(12'h008, 32'h1);
    rd(12'h030, 32'h00058000);
    rd(12'h150, 32'h00000E0F);
    rd(12'h160, 32'h00330003);
    rd(12'h168, 32'h33);
    rd(12'h024, 32'h00001100);
    rd(12'h100, 32'h0);
    rd(12'h16C, 32'h0000002A);
    chk({regulator_b_code, regulator_a_code}, 11'h1CF);
    chk({calibration_mode_select, calibration_analog_enable, auto_calibration_enable}, 3'h3);
    chk(resistor_trim, 6'h2A);
  endtask
  task t_eth;
    logic [31:0] q;
    chk({external_mgmt_path_select, operation_mode, phy_station_number}, 8'h00);
    chk({tx_clock_delay_tap, rx_clock_delay_tap}, 8'h00);
    chk(ref_clock_24mhz, 1);
    wr(12'h030, 32'hFFFFFFFF);
    rd(12'h030, 32'hFFFFBFFF);
    chk(external_mgmt_path_select, 1);
    chk(operation_mode, 2'h3);
    chk(phy_station_number, 5'h1F);
    chk({tx_clock_delay_tap, rx_clock_delay_tap}, 8'hFF);
    chk(rx_clock_invert, 1);
    chk(tx_clock_invert, 1);
    chk({rmii_enable, mii_enable, rgmii_enable}, 3'h4);
    chk({tx_clock_source, rx_clock_invert, tx_clock_invert}, 4'hF);
    wr(12'h030, 32'h4);
    chk({rmii_enable, mii_enable, rgmii_enable}, 3'h1);
    chk(ref_clock_24mhz, 0);
    wr(12'h030, 32'h0);
    chk({rmii_enable, mii_enable, rgmii_enable}, 3'h2);
    bus(1, 12'h030, 32'hFFFFFFFF, 4'h1, q);
    rd(12'h030, 32'h000000FF);
    chk(rx_clock_delay_tap, 5'h07);
    wr(12'h008, 32'h0);
    chk(remap_to_boot, 0);
    wr(12'h008, 32'h1);
    chk(remap_to_boot, 1);
  endtask
  task t_pins;
    boot_select_pin <= 2'h1;
    upgrade_pin <= 0;
    repeat (6) @(posedge clock);
    rd(12'h024, 32'h00000800);
    upgrade_pin <= 1;
    repeat (6) @(posedge clock);
    rd(12'h024, 32'h00000900);
  endtask
  task t_trim;
    wr(12'h150, 32'hFFFFFFFF);
    rd(12'h150, 32'hFF33FF1F);
    chk({regulator_b_code, regulator_a_code}, 11'h7FF);
    wr(12'h168, 32'h15);
    wr(12'h160, 32'h100);
    chk(resistor_trim, 6'h15);
    chk({calibration_mode_select, calibration_analog_enable, auto_calibration_enable}, 3'h0);
    wr(12'h160, 32'h0);
    chk(resistor_trim, 6'h2A);
    wr(12'h160, 32'h7);
    chk({calibration_mode_select, calibration_analog_enable, auto_calibration_enable}, 3'h7);
    calibrator_compare <= 1;
    rd(12'h16C, 32'h0000012A);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    t_reset();
    t_eth();
    t_trim();
    t_pins();
    end_of_test();
  end
endmodule // system_config_regs_tb_top
